// ==== hw/adcs_pkg.sv ====
// Shared constants and types of the converter sequencer.
package adcs_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CONTROL_FIRST = 5'h00;
  localparam logic [4:0] OFS_CONTROL_SECOND = 5'h04;
  localparam logic [4:0] OFS_RESULT_HIGH = 5'h08;
  localparam logic [4:0] OFS_RESULT_LOW = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
  localparam logic [4:0] OFS_GLOBAL_IRQ = 5'h18;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHAN_LSB = 0;
  localparam int FORMAT_BIT = 4;
  localparam int POWER_BIT = 5;
  localparam int BUSY_BIT = 6;
  localparam int START_BIT = 7;
  localparam int DIV_LSB = 0;
  localparam int REF_LSB = 3;
  localparam int SRC_LSB = 5;
  localparam int IRQ_BIT = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_CHAN = 3'h0;
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam logic [1:0] RST_REF = 2'h0;
  localparam logic [1:0] RST_SRC = 2'h0;
  localparam logic [9:0] RST_RESULT = 10'h000;
  // ----------------------------------------------------------------
  // Conversion timing in converter clock periods, first trial code and bus response codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SAMPLE_PERIODS = 4'h4;
  localparam logic [3:0] CONV_PERIODS = 4'hA;
  localparam logic [3:0] TOTAL_PERIODS = 4'hE;
  localparam logic [9:0] TRIAL_FIRST = 10'h200;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } adcs_state_e;
endpackage : adcs_pkg

// ==== hw/adcs_conv_if.sv ====
// Signals between the register front end and the conversion core.
`timescale 1ns/1ps
`default_nettype none
interface adcs_conv_if;
  logic startLevel;
  logic powerOn;
  logic [2:0] divSel;
  logic compSync;
  logic busy;
  logic sampling;
  logic done;
  logic [9:0] result;
  logic [9:0] trialCode;
  modport ctrl (output startLevel, output powerOn, output divSel, output compSync,
                input busy, input sampling, input done, input result, input trialCode);
  modport core (input startLevel, input powerOn, input divSel, input compSync,
                output busy, output sampling, output done, output result, output trialCode);
endinterface : adcs_conv_if
`default_nettype wire

// ==== hw/adcs_conv_core.sv ====
// Converter clock prescaler and successive-approximation sequence.
`timescale 1ns/1ps
`default_nettype none
module adcs_conv_core (
  input wire logic clock,
  input wire logic resetn,
  adcs_conv_if.core conv
);
  adcs_pkg::adcs_state_e state_ff;
  logic [6:0] prescale_ff;
  logic [3:0] count_ff;
  logic [9:0] trial_ff;
  logic [9:0] result_ff;
  logic startPrev_ff;
  logic tick;
  logic abort;
  logic launch;
  logic [9:0] nxt_trial;

  // Mask of prescaler bits that must all be set for one converter clock tick.
  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    div_mask = 7'h7F >> (3'h7 - sel);
  endfunction : div_mask

  assign tick = (prescale_ff & div_mask(conv.divSel)) == div_mask(conv.divSel);
  assign abort = conv.startLevel | ~conv.powerOn;
  assign launch = startPrev_ff & ~conv.startLevel & conv.powerOn;

  // Next trial code: drop the bit under test if the input was below it, try the next one.
  always_comb begin
    nxt_trial = trial_ff;
    if (!conv.compSync) begin
      nxt_trial[count_ff] = 1'b0;
    end
    if (count_ff != 4'h0) begin
      nxt_trial[count_ff - 4'h1] = 1'b1;
    end
  end

  // Start level history for the falling edge.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      startPrev_ff <= 1'b0;
    end else begin
      startPrev_ff <= conv.startLevel;
    end
  end

  // Prescaler restarts on launch so the first sample period is full length.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prescale_ff <= 7'h00;
    end else if (launch) begin
      prescale_ff <= 7'h00;
    end else begin
      prescale_ff <= prescale_ff + 7'h01;
    end
  end

  // Sample for four periods, then decide one bit per period, ten in all.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= adcs_pkg::ST_IDLE;
      count_ff <= 4'h0;
      trial_ff <= adcs_pkg::RST_RESULT;
      result_ff <= adcs_pkg::RST_RESULT;
    end else if (abort) begin
      state_ff <= adcs_pkg::ST_IDLE;
      count_ff <= 4'h0;
      trial_ff <= adcs_pkg::RST_RESULT;
    end else begin
      unique case (state_ff)
        adcs_pkg::ST_IDLE: begin
          if (launch) begin
            state_ff <= adcs_pkg::ST_SAMPLE;
            count_ff <= 4'h0;
          end
        end
        adcs_pkg::ST_SAMPLE: begin
          if (tick) begin
            count_ff <= count_ff + 4'h1;
            if (count_ff == adcs_pkg::SAMPLE_PERIODS - 4'h1) begin
              state_ff <= adcs_pkg::ST_CONVERT;
              count_ff <= adcs_pkg::CONV_PERIODS - 4'h1;
              trial_ff <= adcs_pkg::TRIAL_FIRST;
            end
          end
        end
        adcs_pkg::ST_CONVERT: begin
          if (tick) begin
            trial_ff <= nxt_trial;
            count_ff <= count_ff - 4'h1;
            if (count_ff == 4'h0) begin
              state_ff <= adcs_pkg::ST_IDLE;
              result_ff <= nxt_trial;
            end
          end
        end
      endcase
    end
  end

  assign conv.busy = state_ff != adcs_pkg::ST_IDLE;
  assign conv.sampling = state_ff == adcs_pkg::ST_SAMPLE;
  assign conv.done = (state_ff == adcs_pkg::ST_CONVERT) & tick & (count_ff == 4'h0) & ~abort;
  assign conv.result = result_ff;
  assign conv.trialCode = trial_ff;
endmodule : adcs_conv_core
`default_nettype wire

// ==== hw/adcs_top.sv ====
// Converter sequencer top: AXI4-Lite registers, interrupt and analog controls.
// Behaviour
// - Two-bit reference select field lives in the second control register.
// - Format bit in first control register chooses result alignment across bytes.
// - Interrupt reaches the processor only with global and converter enables set.
// - Busy flag stays high while a conversion is in progress.
// - Busy falls at completion; result bytes then hold valid data.
// - Clearing power enable switches the converter circuitry off.
// - Result is a 10-bit unsigned code, full scale at the reference.
// - Request flag is software clearable; software clears it before enabling.
// - Three-bit divider selects system clock divided by 1 up to 128.
// - Reference 01 is supply, 10 amplifier, 00 and 11 external pin.
// - A conversion is 4 sampling plus 10 conversion periods, 14 total.
// - Source select 00 routes the chosen external channel; others route internal.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module adcs_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparatorHigh,
  output logic convPowerOn,
  output logic refUseSupply,
  output logic refUseAmplifier,
  output logic refUsePin,
  output logic externalRouteOn,
  output logic [2:0] externalChannel,
  output logic [1:0] internalSource,
  output logic sampleHold,
  output logic [9:0] trialCode,
  output logic irq
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [2:0] external_channel_select_ff;
  logic result_format_sel_ff;
  logic conv_power_enable_ff;
  logic start_ff;
  logic [2:0] conv_clock_divider_ff;
  logic [1:0] reference_select_ff;
  logic [1:0] internal_source_select_ff;
  logic conv_irq_request_ff;
  logic conv_irq_enable_ff;
  logic global_irq_enable_ff;
  logic compMeta_ff;
  logic compSync_ff;
  logic irq_ff;

  // ----------------------------------------------------------------
  // Bus channel state
  // ----------------------------------------------------------------
  logic awHeld_ff;
  logic [4:0] awAddr_ff;
  logic wHeld_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic doWrite;
  logic doRead;
  logic wrLow;
  logic [7:0] wrByte;
  logic [7:0] resultHigh;
  logic [7:0] resultLow;
  logic [7:0] readByte;
  logic readHit;
  logic nxt_irq_request;

  adcs_conv_if conv ();

  // Conversion core does the timing; this module only steers it.
  adcs_conv_core u_core (
    .clock(clock),
    .resetn(resetn),
    .conv(conv)
  );

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------

  // The comparator arrives from the analog side, so it is brought in through two flops.
  // Limitation: the two-cycle lag means the lowest divider codes decide on a stale level.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      compMeta_ff <= 1'b0;
      compSync_ff <= 1'b0;
    end else begin
      compMeta_ff <= comparatorHigh;
      compSync_ff <= compMeta_ff;
    end
  end

  // Core steering from register fields.
  assign conv.startLevel = start_ff;
  assign conv.powerOn = conv_power_enable_ff;
  assign conv.divSel = conv_clock_divider_ff;
  assign conv.compSync = compSync_ff;

  // ----------------------------------------------------------------
  // Analog side controls
  // ----------------------------------------------------------------

  // Every analog enable is gated by power, so power off leaves nothing switched on.
  assign convPowerOn = conv_power_enable_ff;
  assign refUseSupply = conv_power_enable_ff & (reference_select_ff == 2'h1);
  assign refUseAmplifier = conv_power_enable_ff & (reference_select_ff == 2'h2);
  assign refUsePin = conv_power_enable_ff & (reference_select_ff[0] ~^ reference_select_ff[1]);
  assign externalRouteOn = conv_power_enable_ff & (internal_source_select_ff == 2'h0);
  assign externalChannel = external_channel_select_ff;
  assign internalSource = internal_source_select_ff;
  assign sampleHold = conv.sampling & conv_power_enable_ff;
  assign trialCode = conv.trialCode;

  // ----------------------------------------------------------------
  // Result alignment
  // ----------------------------------------------------------------

  // Format 0 packs the top eight bits high; format 1 right-justifies the code.
  always_comb begin
    if (result_format_sel_ff) begin
      resultHigh = {6'h00, conv.result[9:8]};
      resultLow = conv.result[7:0];
    end else begin
      resultHigh = conv.result[9:2];
      resultLow = {conv.result[1:0], 6'h00};
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------

  // Address and data are taken in either order; the response waits for both.
  assign s_axi_awready = ~awHeld_ff & ~bvalid_ff;
  assign s_axi_wready = ~wHeld_ff & ~bvalid_ff;
  assign doWrite = awHeld_ff & wHeld_ff & ~bvalid_ff;
  assign wrLow = doWrite & wStrb_ff[0];
  assign wrByte = wData_ff[7:0];

  // Write address holding.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 5'h00;
    end else if (s_axi_awvalid & s_axi_awready) begin
      awHeld_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_ff <= 1'b0;
    end
  end

  // Write data holding.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      wHeld_ff <= 1'b1;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_ff <= 1'b0;
    end
  end

  // Write response; unmapped offsets answer SLVERR.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= adcs_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (awAddr_ff > adcs_pkg::OFS_GLOBAL_IRQ || awAddr_ff[1:0] != 2'h0) ?
                  adcs_pkg::RESP_SLVERR : adcs_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------

  // First control register: channel, format, power and start.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      external_channel_select_ff <= adcs_pkg::RST_CHAN;
      result_format_sel_ff <= 1'b0;
      conv_power_enable_ff <= 1'b0;
      start_ff <= 1'b0;
    end else if (wrLow && awAddr_ff == adcs_pkg::OFS_CONTROL_FIRST) begin
      external_channel_select_ff <= wrByte[adcs_pkg::CHAN_LSB +: 3];
      result_format_sel_ff <= wrByte[adcs_pkg::FORMAT_BIT];
      conv_power_enable_ff <= wrByte[adcs_pkg::POWER_BIT];
      start_ff <= wrByte[adcs_pkg::START_BIT];
    end
  end

  // Second control register: divider, reference and source.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_clock_divider_ff <= adcs_pkg::RST_DIV;
      reference_select_ff <= adcs_pkg::RST_REF;
      internal_source_select_ff <= adcs_pkg::RST_SRC;
    end else if (wrLow && awAddr_ff == adcs_pkg::OFS_CONTROL_SECOND) begin
      conv_clock_divider_ff <= wrByte[adcs_pkg::DIV_LSB +: 3];
      reference_select_ff <= wrByte[adcs_pkg::REF_LSB +: 2];
      internal_source_select_ff <= wrByte[adcs_pkg::SRC_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------

  // Completion sets the flag on the edge where busy falls; a set in the clearing
  // cycle wins so that a conversion finishing under a clear is not lost.
  always_comb begin
    nxt_irq_request = conv_irq_request_ff;
    if (wrLow && awAddr_ff == adcs_pkg::OFS_IRQ_STATUS && wrByte[adcs_pkg::IRQ_BIT]) begin
      nxt_irq_request = 1'b0;
    end
    if (conv.done) begin
      nxt_irq_request = 1'b1;
    end
  end

  // Request flag.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_irq_request_ff <= 1'b0;
    end else begin
      conv_irq_request_ff <= nxt_irq_request;
    end
  end

  // Converter enable acts as the mask.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conv_irq_enable_ff <= 1'b0;
    end else if (wrLow && awAddr_ff == adcs_pkg::OFS_IRQ_MASK) begin
      conv_irq_enable_ff <= wrByte[adcs_pkg::IRQ_BIT];
    end
  end

  // Global enable.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      global_irq_enable_ff <= 1'b0;
    end else if (wrLow && awAddr_ff == adcs_pkg::OFS_GLOBAL_IRQ) begin
      global_irq_enable_ff <= wrByte[adcs_pkg::IRQ_BIT];
    end
  end

  // Registered so the output is glitch free; it rises on the edge that sets the flag.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq_request & conv_irq_enable_ff & global_irq_enable_ff;
    end
  end

  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------

  assign s_axi_arready = ~rvalid_ff;
  assign doRead = s_axi_arvalid & ~rvalid_ff;

  // Read mux; busy reads live so polling sees completion at once.
  always_comb begin
    readByte = 8'h00;
    readHit = (s_axi_araddr[1:0] == 2'h0);
    unique case (s_axi_araddr)
      adcs_pkg::OFS_CONTROL_FIRST: begin
        readByte[adcs_pkg::CHAN_LSB +: 3] = external_channel_select_ff;
        readByte[adcs_pkg::FORMAT_BIT] = result_format_sel_ff;
        readByte[adcs_pkg::POWER_BIT] = conv_power_enable_ff;
        readByte[adcs_pkg::BUSY_BIT] = conv.busy;
        readByte[adcs_pkg::START_BIT] = start_ff;
      end
      adcs_pkg::OFS_CONTROL_SECOND: begin
        readByte[adcs_pkg::DIV_LSB +: 3] = conv_clock_divider_ff;
        readByte[adcs_pkg::REF_LSB +: 2] = reference_select_ff;
        readByte[adcs_pkg::SRC_LSB +: 2] = internal_source_select_ff;
      end
      adcs_pkg::OFS_RESULT_HIGH: begin
        readByte = resultHigh;
      end
      adcs_pkg::OFS_RESULT_LOW: begin
        readByte = resultLow;
      end
      adcs_pkg::OFS_IRQ_STATUS: begin
        readByte[adcs_pkg::IRQ_BIT] = conv_irq_request_ff;
      end
      adcs_pkg::OFS_IRQ_MASK: begin
        readByte[adcs_pkg::IRQ_BIT] = conv_irq_enable_ff;
      end
      adcs_pkg::OFS_GLOBAL_IRQ: begin
        readByte[adcs_pkg::IRQ_BIT] = global_irq_enable_ff;
      end
      default: begin
        readHit = 1'b0;
      end
    endcase
  end

  // Read data and response, held until taken.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= adcs_pkg::RESP_OKAY;
    end else if (doRead) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h000000, readByte};
      rresp_ff <= readHit ? adcs_pkg::RESP_OKAY : adcs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Protection attributes carry no meaning for this block.
  logic unusedProt;
  assign unusedProt = ^{s_axi_awprot, s_axi_arprot, wData_ff[31:8], wStrb_ff[3:1]};
endmodule : adcs_top
`default_nettype wire

// ==== dv/adcs_top_assertions.sv ====
// Port-level assertions for the converter sequencer top.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------
// Checker
// ----------------------------------------------------------
module adcs_top_assertions (
  input wire logic clock,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic convPowerOn,
  input wire logic refUseSupply,
  input wire logic refUseAmplifier,
  input wire logic refUsePin,
  input wire logic externalRouteOn,
  input wire logic sampleHold,
  input wire logic irq
);
  // One clock domain, so clocking and reset qualification are shared.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_refPick;
    convPowerOn |-> $onehot({refUseSupply, refUseAmplifier, refUsePin}); endproperty
  a_refPick: assert property (p_refPick) else $error("reference not one-hot");
  property p_offQuiet; !convPowerOn |-> !(refUseSupply || refUseAmplifier || refUsePin
    || externalRouteOn || sampleHold); endproperty
  a_offQuiet: assert property (p_offQuiet) else $error("analog active while off");
  property p_sampleLen; $rose(sampleHold) |-> sampleHold [*4]; endproperty
  a_sampleLen: assert property (p_sampleLen) else $error("sampling too short");
  property p_irqIdle; $rose(irq) |-> !sampleHold; endproperty
  a_irqIdle: assert property (p_irqIdle) else $error("irq during sampling");
  property p_wResp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid; endproperty
  a_wResp: assert property (p_wResp) else $error("write response missing");
  property p_bDrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bDrop: assert property (p_bDrop) else $error("write response repeated");
  property p_rResp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rResp: assert property (p_rResp) else $error("read response missing");
  property p_arBlock; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arBlock: assert property (p_arBlock) else $error("read taken while answering");
  c_done: cover property ($rose(irq));
  c_sample: cover property ($fell(sampleHold));
  c_amp: cover property (refUseAmplifier);
endmodule : adcs_top_assertions
bind adcs_top adcs_top_assertions u_adcs_top_assertions (.*);
`default_nettype wire

// ==== dv/tb_adc_conversion_sequencer.sv ====
// Self-checking bench for the converter sequencer top.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_sequencer;
  // ----------------------------------------------------------
  // Stimulus, design and cycle monitor
  // ----------------------------------------------------------
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, comparatorHigh = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, internalSource;
  logic [31:0] s_axi_rdata;
  logic convPowerOn, refUseSupply, refUseAmplifier, refUsePin, externalRouteOn, sampleHold;
  logic [2:0] externalChannel;
  logic [9:0] trialCode;
  logic shSeen = 1'b0;
  int runCnt = 0, holdCnt = 0, errCount = 0, comparisons = 0;
  adcs_top u_adcs_top (.*);
  always #25 clock = ~clock;
  // Sampling length and cycles from sampling start to irq.
  always @(posedge clock) begin
    shSeen <= sampleHold;
    if (sampleHold && !shSeen) begin
      runCnt <= 1;
      holdCnt <= 1;
    end else begin
      if (!irq) runCnt <= runCnt + 1;
      if (sampleHold) holdCnt <= holdCnt + 1;
    end
  end
  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic stop_test;
    if (errCount == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic hang;
    errCount++;
    stop_test();
  endtask : hang
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Unmapped or unaligned offsets answer with an error.
  function automatic logic [1:0] respFor(input logic [4:0] a);
    return (a > 5'h18 || a[1:0] != 2'h0) ? adcs_pkg::RESP_SLVERR : adcs_pkg::RESP_OKAY;
  endfunction : respFor
  // Each request stands until its ready is seen high at a rising edge.
  task automatic axiWrite(input logic [4:0] a, input logic [7:0] d);
    int i;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (i = 0; i < 200; i++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 200) hang();
    check("write response", respFor(a), s_axi_bresp);
  endtask : axiWrite
  task automatic axiRead(input logic [4:0] a, output logic [31:0] data);
    int i;
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (i = 0; i < 200; i++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    data = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (i == 200) hang();
    check("read response", respFor(a), s_axi_rresp);
  endtask : axiRead
  task automatic rdChk(input logic [4:0] a, input logic [7:0] exp, input string what);
    logic [31:0] v;
    axiRead(a, v);
    check(what, {24'h0, exp}, v);
  endtask : rdChk
  task automatic waitIrq;
    int i;
    for (i = 0; i < 4000; i++) begin
      @(negedge clock);
      if (irq === 1'b1) break;
    end
    if (i == 4000) hang();
  endtask : waitIrq
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic tRegs;
    for (int k = 0; k < 8; k++) rdChk(5'(k * 4), 8'h00, "reset value");
    axiWrite(5'h1C, 8'hFF);
    axiWrite(5'h08, 8'h55);
    rdChk(5'h08, 8'h00, "result high read-only");
  endtask : tRegs
  task automatic tRoute;
    axiWrite(5'h00, 8'h25);
    for (int k = 0; k < 16; k++) begin
      axiWrite(5'h04, 8'(k << 3));
      @(negedge clock);
      check("reference", {k[1:0] == 1, k[1:0] == 2, k[1:0] == 0 || k[1:0] == 3},
        {refUseSupply, refUseAmplifier, refUsePin});
      check("route", k[3:2] == 0, externalRouteOn);
    end
    check("channel", 3'h5, externalChannel);
    rdChk(5'h04, 8'h78, "second control");
    axiWrite(5'h00, 8'h05);
    @(negedge clock);
    check("power off", 5'h00, {refUseSupply, refUseAmplifier, refUsePin, externalRouteOn,
      convPowerOn});
  endtask : tRoute
  // Each divider code once; comparator level alternates, format changes every second code.
  task automatic tConv;
    logic f;
    logic [9:0] res;
    axiWrite(5'h10, 8'h01);
    axiWrite(5'h14, 8'h01);
    axiWrite(5'h18, 8'h01);
    for (int d = 0; d < 8; d++) begin
      f = d[1];
      res = d[0] ? 10'h000 : 10'h3FF;
      comparatorHigh <= ~d[0];
      axiWrite(5'h04, 8'(d));
      axiWrite(5'h00, {3'b101, f, 4'h0});
      axiWrite(5'h00, {3'b001, f, 4'h0});
      waitIrq();
      check("sampling cycles", 4 << d, holdCnt);
      check("cycles to irq", 14 << d, runCnt);
      rdChk(5'h00, {3'b001, f, 4'h0}, "busy cleared");
      rdChk(5'h08, f ? {6'h0, res[9:8]} : res[9:2], "result high");
      rdChk(5'h0C, f ? res[7:0] : {res[1:0], 6'h0}, "result low");
      rdChk(5'h10, 8'h01, "request flag");
      axiWrite(5'h10, 8'h01);
      @(negedge clock);
      check("irq after clear", 1'b0, irq);
    end
  endtask : tConv
  task automatic tPoll;
    int i;
    logic [31:0] v;
    axiWrite(5'h18, 8'h00);
    axiWrite(5'h04, 8'h01);
    axiWrite(5'h00, 8'hA0);
    axiWrite(5'h00, 8'h20);
    axiRead(5'h00, v);
    check("busy during run", 32'h60, v);
    for (i = 0; i < 100; i++) begin
      axiRead(5'h00, v);
      if (v[6] === 1'b0) break;
    end
    if (i == 100) hang();
    check("irq masked", 1'b0, irq);
    rdChk(5'h10, 8'h01, "polled flag");
    axiWrite(5'h18, 8'h01);
    @(negedge clock);
    check("irq unmasked", 1'b1, irq);
    axiWrite(5'h10, 8'h01);
  endtask : tPoll
  task automatic tAbort;
    axiWrite(5'h04, 8'h03);
    axiWrite(5'h00, 8'hA0);
    axiWrite(5'h00, 8'h20);
    repeat (30) @(posedge clock);
    axiWrite(5'h00, 8'hA0);
    rdChk(5'h00, 8'hA0, "busy after abort");
    axiWrite(5'h00, 8'h20);
    repeat (30) @(posedge clock);
    axiWrite(5'h00, 8'h00);
    rdChk(5'h00, 8'h00, "busy after power off");
    repeat (150) @(posedge clock);
    rdChk(5'h10, 8'h00, "no request after abort");
  endtask : tAbort
  // Reset for twelve cycles, then each scenario.
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    tRegs();
    tRoute();
    tConv();
    tPoll();
    tAbort();
    stop_test();
  end
endmodule : tb_adc_conversion_sequencer
`default_nettype wire
